// ===== include/pss_defines.svh
// Constants of the position selector switch
//
// Overview of operation
// - Advance edge steps up, wraps to one
// - Code word used only within range
// - Code above limit: range alarm 3 s, except while stepping
// - Advance timeout mode: apply after inactivity
// - Advance confirm missing: discard, alarm 3 s
// - Advance confirm edge applies, only confirm mode
// - Code bit 2 MSB; zero is rest
// - Code timeout mode: apply after last change
// - Code confirm edge applies, else alarm 3 s
// - Stepping and coded sequences lock out mutually
// - Separate confirm inputs and modes per source
// - Applied position saved to non-volatile store
// - Recall policy restores; bad value gives zero
// - Follow policy: zero plus alarm, then code
// - Failed sync: position zero, start-up alarm
// - Follow-then-recall falls back to stored value
// - Log position changes and confirm timeouts
// - Change-initiated and in-use notices
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH
`define PSS_CLK_HZ        32'h0BEB_C200
`define PSS_TICK_HZ       32'h0000_03E8
`define PSS_ALARM_MS      16'h0BB8
`define PSS_POWER_CYC_MS  16'h0028
`define PSS_POS_ZERO      3'h0
`define PSS_POS_ONE       3'h1
`define PSS_MODE_TIMEOUT  1'b0
`define PSS_MODE_CONFIRM  1'b1
`endif

// ===== include/pss_pkg.sv
// Types of the position selector switch
`default_nettype none
package pss_pkg;
   typedef enum logic [1:0] {
      PSS_PWR_RECALL,
      PSS_PWR_FOLLOW,
      PSS_PWR_FOLLOW_RECALL
   } pss_policy_t;

   typedef struct packed {
      logic       advanceMode;
      logic       codeMode;
      logic [2:0] upperLimit;
      logic [15:0] timeoutMs;
      logic       logEnable;
   } pss_config_t;

   typedef struct packed {
      logic       valid;
      logic [1:0] kind;
      logic [2:0] position;
   } pss_event_t;

   typedef enum logic [1:0] {
      PSS_EV_POSITION,
      PSS_EV_ADV_TIMEOUT,
      PSS_EV_CODE_TIMEOUT
   } pss_event_kind_t;
endpackage
`default_nettype wire

// ===== rtl/pss_selector.sv
// Position selector switch logic
`include "pss_defines.svh"
`default_nettype none
module pss_selector #(
   parameter int NOTICE_MS = 1000,
   parameter int TICK_DIV  = `PSS_CLK_HZ / `PSS_TICK_HZ
) (
   // Clock and reset
   input  wire logic                  clock,
   input  wire logic                  sys_rst,
   // Configuration
   input  wire pss_pkg::pss_config_t  cfg,
   input  wire pss_pkg::pss_policy_t  startupPolicy,
   // Discrete inputs
   input  wire logic                  advance,
   input  wire logic                  advanceConfirm,
   input  wire logic                  code_bit_0,
   input  wire logic                  code_bit_1,
   input  wire logic                  code_bit_2,
   input  wire logic                  code_confirm,
   // Non-volatile store
   input  wire logic [2:0]            nvStoredPos,
   output logic                       nvWrite,
   output logic [2:0]                 nvWriteData,
   // Position outputs
   output logic [7:1]                 positionOneHot,
   output logic [2:0]                 positionWord,
   output logic [2:0]                 preselectPos,
   // Alarms
   output logic                       rangeAlarm,
   output logic                       advance_confirm_alarm,
   output logic                       codeConfirmAlarm,
   output logic                       startup_alarm,
   // Notices and log
   output logic                       changeNotice,
   output logic                       inUseNotice,
   output pss_pkg::pss_event_t        logEvent
);
   typedef enum logic [2:0] {
      ST_POWERUP,
      ST_IDLE,
      ST_STEP,
      ST_CODE
   } pss_state_t;

   pss_state_t  state_r;
   logic [17:0] divCnt_r;
   logic        tick;
   logic [4:0]  sync1_r;
   logic [4:0]  sync2_r;
   logic [4:0]  prev_r;
   logic        advS1_r;
   logic        advS2_r;
   logic        advPrev_r;
   logic        advEdge;
   logic        advAckRise;
   logic        codeAckRise;
   logic [2:0]  codeWord;
   logic        codeChange;
   logic [15:0] toCnt_r;
   logic [15:0] puCnt_r;
   logic [15:0] rangeCnt_r;
   logic [15:0] advAlmCnt_r;
   logic [15:0] codeAlmCnt_r;
   logic [15:0] noticeCnt_r;
   logic [15:0] useCnt_r;
   logic [2:0]  applied_r;
   logic        applyNow;
   logic [2:0]  applyPos;
   logic        advTimeout;
   logic        codeTimeout;
   logic        puAlarm_r;
   logic        codeInRange;

   always_ff @(posedge clock) begin
      if (sys_rst || divCnt_r == 18'(TICK_DIV - 1)) begin
         divCnt_r <= '0;
      end else begin
         divCnt_r <= divCnt_r + 18'h0_0001;
      end
   end
   assign tick = (divCnt_r == 18'(TICK_DIV - 1));

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sync1_r <= '0;
         sync2_r <= '0;
         prev_r  <= '0;
      end else begin
         sync1_r <= {code_confirm, advanceConfirm, code_bit_2, code_bit_1, code_bit_0};
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   // Code decoded with bit 2 as MSB
   assign codeWord    = sync2_r[2:0];
   assign codeChange  = (sync2_r[2:0] != prev_r[2:0]);
   assign codeInRange = (codeWord != `PSS_POS_ZERO) && (codeWord <= cfg.upperLimit);
   assign advAckRise  = sync2_r[3] & ~prev_r[3];
   assign codeAckRise = sync2_r[4] & ~prev_r[4];

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         advS1_r   <= 1'b0;
         advS2_r   <= 1'b0;
         advPrev_r <= 1'b0;
      end else begin
         advS1_r   <= advance;
         advS2_r   <= advS1_r;
         advPrev_r <= advS2_r;
      end
   end
   assign advEdge = advS2_r & ~advPrev_r;

   assign advTimeout  = (state_r == ST_STEP) && tick && (toCnt_r + 16'h0001 >= cfg.timeoutMs);
   assign codeTimeout = (state_r == ST_CODE) && tick && (toCnt_r + 16'h0001 >= cfg.timeoutMs);

   // Sequence control and apply decision
   always_comb begin
      applyNow = 1'b0;
      applyPos = preselectPos;
      unique case (state_r)
         ST_POWERUP: begin
            if (tick && puCnt_r + 16'h0001 >= `PSS_POWER_CYC_MS) begin
               applyNow = 1'b1;
               if (startupPolicy == pss_pkg::PSS_PWR_RECALL) begin
                  applyPos = (nvStoredPos <= cfg.upperLimit) ? nvStoredPos : `PSS_POS_ZERO;
               end else if (codeInRange) begin
                  applyPos = codeWord;
               end else if (startupPolicy == pss_pkg::PSS_PWR_FOLLOW_RECALL &&
                            nvStoredPos <= cfg.upperLimit) begin
                  applyPos = nvStoredPos;
               end else begin
                  applyPos = `PSS_POS_ZERO;
               end
            end
         end
         ST_STEP: begin
            if (cfg.advanceMode == `PSS_MODE_TIMEOUT) begin
               applyNow = advTimeout && !advEdge;
            end else begin
               applyNow = advAckRise;
            end
         end
         ST_CODE: begin
            if (cfg.codeMode == `PSS_MODE_TIMEOUT) begin
               applyNow = codeTimeout && !codeChange;
            end else begin
               applyNow = codeAckRise;
            end
         end
         default: begin
            applyNow = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_r      <= ST_POWERUP;
         preselectPos <= `PSS_POS_ZERO;
         toCnt_r      <= '0;
      end else begin
         unique case (state_r)
            ST_POWERUP: begin
               if (applyNow) begin
                  state_r <= ST_IDLE;
               end
            end
            ST_IDLE: begin
               toCnt_r <= '0;
               if (advEdge) begin
                  state_r      <= ST_STEP;
                  preselectPos <= (applied_r >= cfg.upperLimit) ? `PSS_POS_ONE
                                                                : applied_r + `PSS_POS_ONE;
               end else if (codeChange && codeInRange) begin
                  state_r      <= ST_CODE;
                  preselectPos <= codeWord;
               end
            end
            ST_STEP: begin
               if (advEdge) begin
                  toCnt_r      <= '0;
                  preselectPos <= (preselectPos >= cfg.upperLimit) ? `PSS_POS_ONE
                                                                   : preselectPos + `PSS_POS_ONE;
               end else if (applyNow || advTimeout) begin
                  state_r <= ST_IDLE;
               end else if (tick) begin
                  toCnt_r <= toCnt_r + 16'h0001;
               end
            end
            ST_CODE: begin
               if (codeChange) begin
                  toCnt_r <= '0;
                  if (codeInRange) begin
                     preselectPos <= codeWord;
                  end
               end else if (applyNow || codeTimeout) begin
                  state_r <= ST_IDLE;
               end else if (tick) begin
                  toCnt_r <= toCnt_r + 16'h0001;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Power-up delay counter and start-up alarm
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         puCnt_r   <= '0;
         puAlarm_r <= 1'b0;
      end else if (state_r == ST_POWERUP) begin
         puAlarm_r <= (startupPolicy != pss_pkg::PSS_PWR_RECALL);
         if (tick) begin
            puCnt_r <= puCnt_r + 16'h0001;
         end
         if (applyNow) begin
            puAlarm_r <= (applyPos == `PSS_POS_ZERO);
         end
      end else if (applyNow && applyPos != `PSS_POS_ZERO) begin
         puAlarm_r <= 1'b0;
      end
   end
   assign startup_alarm = puAlarm_r;

   // Applied position and non-volatile write
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         applied_r   <= `PSS_POS_ZERO;
         nvWrite     <= 1'b0;
         nvWriteData <= `PSS_POS_ZERO;
      end else begin
         nvWrite <= 1'b0;
         if (applyNow) begin
            applied_r   <= applyPos;
            nvWrite     <= 1'b1;
            nvWriteData <= applyPos;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         positionWord <= `PSS_POS_ZERO;
      end else begin
         positionWord <= applied_r;
      end
   end
   for (genvar i = 1; i <= 7; i++) begin : g_hot
      always_ff @(posedge clock) begin
         if (sys_rst) begin
            positionOneHot[i] <= 1'b0;
         end else begin
            positionOneHot[i] <= (applied_r == 3'(i));
         end
      end
   end

   // Hold timers for alarms and notices
   function automatic logic [15:0] holdNext(input logic start, input logic [15:0] cnt,
                                            input logic [15:0] len);
      if (start) begin
         return len;
      end else if (tick && cnt != 16'h0000) begin
         return cnt - 16'h0001;
      end
      return cnt;
   endfunction

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rangeCnt_r   <= '0;
         advAlmCnt_r  <= '0;
         codeAlmCnt_r <= '0;
         noticeCnt_r  <= '0;
         useCnt_r     <= '0;
      end else begin
         rangeCnt_r   <= holdNext(codeChange && codeWord > cfg.upperLimit &&
                                  state_r != ST_STEP, rangeCnt_r, `PSS_ALARM_MS);
         advAlmCnt_r  <= holdNext(advTimeout && cfg.advanceMode == `PSS_MODE_CONFIRM &&
                                  !applyNow && !advEdge, advAlmCnt_r, `PSS_ALARM_MS);
         codeAlmCnt_r <= holdNext(codeTimeout && cfg.codeMode == `PSS_MODE_CONFIRM &&
                                  !applyNow && !codeChange, codeAlmCnt_r, `PSS_ALARM_MS);
         noticeCnt_r  <= holdNext(advEdge && state_r != ST_CODE && state_r != ST_POWERUP,
                                  noticeCnt_r, 16'(NOTICE_MS));
         useCnt_r     <= holdNext(applyNow, useCnt_r, 16'(NOTICE_MS));
      end
   end
   assign rangeAlarm            = (rangeCnt_r != 16'h0000);
   assign advance_confirm_alarm = (advAlmCnt_r != 16'h0000);
   assign codeConfirmAlarm      = (codeAlmCnt_r != 16'h0000);
   assign changeNotice          = (noticeCnt_r != 16'h0000);
   assign inUseNotice           = (useCnt_r != 16'h0000);

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         logEvent <= '0;
      end else begin
         logEvent <= '0;
         if (cfg.logEnable) begin
            if (applyNow && applyPos != applied_r) begin
               logEvent <= {1'b1, pss_pkg::PSS_EV_POSITION, applyPos};
            end else if (advTimeout && cfg.advanceMode == `PSS_MODE_CONFIRM &&
                         !applyNow && !advEdge) begin
               logEvent <= {1'b1, pss_pkg::PSS_EV_ADV_TIMEOUT, preselectPos};
            end else if (codeTimeout && cfg.codeMode == `PSS_MODE_CONFIRM &&
                         !applyNow && !codeChange) begin
               logEvent <= {1'b1, pss_pkg::PSS_EV_CODE_TIMEOUT, preselectPos};
            end
         end
      end
   end
endmodule // pss_selector
`default_nettype wire

// ===== tb/pss_switch_panel.sv
// Pushbutton and contact input model for the selector
`default_nettype none
module pss_switch_panel #(
   parameter int GAP = 32'h0098_9680
) (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       sys_rst,
   // Requests from the bench
   input  wire logic       pressReq,
   input  wire logic [2:0] codeReq,
   // Contact outputs
   output var  logic       advance,
   output var  logic       code_bit_0,
   output var  logic       code_bit_1,
   output var  logic       code_bit_2
);
   timeunit 1ns;
   timeprecision 100ps;
   int gapCnt_r;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         gapCnt_r <= 0;
         advance  <= 1'b0;
      end else begin
         advance <= pressReq && (gapCnt_r == 0);
         if (pressReq && (gapCnt_r == 0)) begin
            gapCnt_r <= GAP;
         end else if (gapCnt_r != 0) begin
            gapCnt_r <= gapCnt_r - 1;
         end
      end
   end
   always_ff @(posedge clock) begin
      {code_bit_2, code_bit_1, code_bit_0} <= codeReq;
   end
endmodule // pss_switch_panel
`default_nettype wire

// ===== tb/pss_selector_asserts.sv
// Checker of the position selector switch
`include "pss_defines.svh"
`default_nettype none
module pss_selector_asserts #(
   parameter int NOTICE_MS = 1000
) (
   input wire logic                 clock,
   input wire logic                 sys_rst,
   input wire pss_pkg::pss_config_t cfg,
   input wire logic                 nvWrite,
   input wire logic [7:1]           positionOneHot,
   input wire logic [2:0]           positionWord,
   input wire logic [2:0]           preselectPos,
   input wire logic                 rangeAlarm,
   input wire logic                 advance_confirm_alarm,
   input wire logic                 codeConfirmAlarm,
   input wire logic                 inUseNotice,
   input wire pss_pkg::pss_event_t  logEvent
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   a_onehot_matches_word: assert property (
      positionOneHot == ((positionWord == 3'h0) ? 7'h00 : (7'h01 << (positionWord - 3'h1))))
      else $error("one-hot output disagrees with binary word");
   a_store_single_pulse: assert property (nvWrite |=> !nvWrite)
      else $error("store write longer than one cycle");
   a_log_needs_enable: assert property (logEvent.valid |-> cfg.logEnable)
      else $error("log event while logging disabled");
   a_log_kind_legal: assert property (logEvent.valid |-> logEvent.kind != 2'h3)
      else $error("log event of unknown kind");
   a_range_alarm_hold: assert property ($rose(rangeAlarm) |-> rangeAlarm [*8])
      else $error("range alarm dropped early");
   a_adv_alarm_mode: assert property (
      $rose(advance_confirm_alarm) |-> cfg.advanceMode == `PSS_MODE_CONFIRM)
      else $error("advance alarm outside confirm mode");
   a_code_alarm_mode: assert property (
      $rose(codeConfirmAlarm) |-> cfg.codeMode == `PSS_MODE_CONFIRM)
      else $error("code alarm outside confirm mode");
   a_preselect_in_range: assert property (preselectPos <= cfg.upperLimit)
      else $error("pending position above upper limit");
   a_in_use_hold: assert property ($rose(inUseNotice) |-> inUseNotice [*8])
      else $error("in-use notice dropped early");
endmodule // pss_selector_asserts
bind pss_selector pss_selector_asserts #(.NOTICE_MS(NOTICE_MS)) chk_u (
   .clock(clock), .sys_rst(sys_rst), .cfg(cfg), .nvWrite(nvWrite),
   .positionOneHot(positionOneHot), .positionWord(positionWord),
   .preselectPos(preselectPos), .rangeAlarm(rangeAlarm),
   .advance_confirm_alarm(advance_confirm_alarm), .codeConfirmAlarm(codeConfirmAlarm),
   .inUseNotice(inUseNotice), .logEvent(logEvent));
`default_nettype wire

// ===== tb/pss_selector_test.sv
// Testbench of the position selector switch
`default_nettype none
module pss_selector_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic                 clock, sys_rst, pressReq, advanceConfirm, code_confirm;
   logic                 advance, code_bit_0, code_bit_1, code_bit_2, nvWrite;
   logic [2:0]           codeReq, nvStoredPos, nvWriteData, positionWord, preselectPos;
   logic [7:1]           positionOneHot;
   logic                 rangeAlarm, advance_confirm_alarm, codeConfirmAlarm, startup_alarm;
   logic                 changeNotice, inUseNotice;
   pss_pkg::pss_config_t cfg;
   pss_pkg::pss_policy_t startupPolicy;
   pss_pkg::pss_event_t  logEvent, lastLog;
   int                   error_cnt, n_checks, nvCnt, logCnt;

   // Fast tick: one ms is four clocks, so 50 ms is 200 clocks
   pss_switch_panel #(.GAP(32'h0000_00C8)) panel_u (.clock(clock), .sys_rst(sys_rst),
      .pressReq(pressReq),
      .codeReq(codeReq), .advance(advance), .code_bit_0(code_bit_0),
      .code_bit_1(code_bit_1), .code_bit_2(code_bit_2));
   pss_selector #(.NOTICE_MS(5), .TICK_DIV(32'h0000_0004)) dut_u (.clock(clock),
      .sys_rst(sys_rst), .cfg(cfg),
      .startupPolicy(startupPolicy), .advance(advance), .advanceConfirm(advanceConfirm),
      .code_bit_0(code_bit_0), .code_bit_1(code_bit_1), .code_bit_2(code_bit_2),
      .code_confirm(code_confirm), .nvStoredPos(nvStoredPos), .nvWrite(nvWrite),
      .nvWriteData(nvWriteData), .positionOneHot(positionOneHot),
      .positionWord(positionWord), .preselectPos(preselectPos), .rangeAlarm(rangeAlarm),
      .advance_confirm_alarm(advance_confirm_alarm), .codeConfirmAlarm(codeConfirmAlarm),
      .startup_alarm(startup_alarm), .changeNotice(changeNotice),
      .inUseNotice(inUseNotice), .logEvent(logEvent));

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // Store writes and log events seen
   always @(posedge clock) begin
      if (nvWrite === 1'b1) nvCnt++;
      if (logEvent.valid === 1'b1) begin
         logCnt++;
         lastLog = logEvent;
      end
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clock);
   endtask

   // Outputs idle after reset
   task automatic check_idle();
      check("positionWord", 16'(positionWord), 16'h0000);
      check("positionOneHot", 16'(positionOneHot), 16'h0000);
      check("preselectPos", 16'(preselectPos), 16'h0000);
      check("alarms", 16'({rangeAlarm, advance_confirm_alarm, codeConfirmAlarm}), 16'h0000);
      check("startup_alarm", 16'(startup_alarm), 16'h0000);
      check("notices", 16'({changeNotice, inUseNotice}), 16'h0000);
      check("nvWrite", 16'(nvWrite), 16'h0000);
   endtask

   // Advance press during power-up window ignored
   task automatic test_advance_window();
      pressReq <= 1'b1;
      step(1);
      pressReq <= 1'b0;
      step(20);
      check("preselectPos", 16'(preselectPos), 16'h0000);
      check("changeNotice", 16'(changeNotice), 16'h0000);
   endtask

   // Code words during power-up: no selection, range alarm
   task automatic test_code_window();
      codeReq <= 3'h7;
      step(20);
      check("rangeAlarm", 16'(rangeAlarm), 16'h0001);
      check("preselectPos", 16'(preselectPos), 16'h0000);
      codeReq <= 3'h3;
      step(20);
      check("preselectPos", 16'(preselectPos), 16'h0000);
      codeReq <= 3'h0;
      step(5);
   endtask

   // Confirm edges during power-up window ignored
   task automatic test_confirm_window();
      advanceConfirm <= 1'b1;
      code_confirm   <= 1'b1;
      step(4);
      advanceConfirm <= 1'b0;
      code_confirm   <= 1'b0;
      step(20);
      check("positionWord", 16'(positionWord), 16'h0000);
      check("codeConfirmAlarm", 16'(codeConfirmAlarm), 16'h0000);
      check("nvCnt", 16'(nvCnt), 16'h0000);
      check("logCnt", 16'(logCnt), 16'h0000);
   endtask

   // Recall start-up applies the stored position
   task automatic test_recall_apply();
      step(150);
      check("positionWord", 16'(positionWord), 16'h0002);
      check("positionOneHot", 16'(positionOneHot), 16'h0002);
      check("nvWriteData", 16'(nvWriteData), 16'h0002);
      check("nvCnt", 16'(nvCnt), 16'h0001);
      check("lastLog", 16'(lastLog), 16'({1'b1, pss_pkg::PSS_EV_POSITION, 3'h2}));
      check("startup_alarm", 16'(startup_alarm), 16'h0000);
   endtask

   // Stepping in timeout mode, with wrap
   task automatic test_step_timeout(input logic [2:0] exp);
      pressReq <= 1'b1;
      step(1);
      pressReq <= 1'b0;
      step(6);
      check("preselectPos", 16'(preselectPos), 16'(exp));
      check("changeNotice", 16'(changeNotice), 16'h0001);
      step(25);
      check("positionWord", 16'(positionWord), 16'(exp));
      check("positionOneHot", 16'(positionOneHot), 16'h0001 << (exp - 3'h1));
      check("nvWriteData", 16'(nvWriteData), 16'(exp));
      check("inUseNotice", 16'(inUseNotice), 16'h0001);
      step(200);
   endtask

   // Stepping in confirm mode: missed, then given
   task automatic test_step_confirm();
      cfg.advanceMode <= 1'b1;
      pressReq        <= 1'b1;
      step(1);
      pressReq <= 1'b0;
      step(40);
      check("advance_confirm_alarm", 16'(advance_confirm_alarm), 16'h0001);
      check("positionWord", 16'(positionWord), 16'h0001);
      check("logCnt", 16'(logCnt), 16'h0005);
      check("lastLog", 16'(lastLog), 16'({1'b1, pss_pkg::PSS_EV_ADV_TIMEOUT, 3'h2}));
      step(170);
      pressReq <= 1'b1;
      step(1);
      pressReq <= 1'b0;
      step(8);
      advanceConfirm <= 1'b1;
      step(2);
      advanceConfirm <= 1'b0;
      step(6);
      check("positionWord", 16'(positionWord), 16'h0002);
      step(200);
   endtask

   // Coded selection, lockout of stepping, missed code confirm
   task automatic test_code_path();
      codeReq <= 3'h3;
      step(8);
      check("preselectPos", 16'(preselectPos), 16'h0003);
      pressReq <= 1'b1;
      step(1);
      pressReq <= 1'b0;
      step(6);
      check("preselectPos", 16'(preselectPos), 16'h0003);
      check("changeNotice", 16'(changeNotice), 16'h0000);
      step(25);
      check("positionWord", 16'(positionWord), 16'h0003);
      check("nvCnt", 16'(nvCnt), 16'h0006);
      check("logCnt", 16'(logCnt), 16'h0007);
      check("lastLog", 16'(lastLog), 16'({1'b1, pss_pkg::PSS_EV_POSITION, 3'h3}));
      codeReq <= 3'h0;
      step(10);
      check("positionWord", 16'(positionWord), 16'h0003);
      cfg.codeMode <= 1'b1;
      codeReq      <= 3'h1;
      step(40);
      check("codeConfirmAlarm", 16'(codeConfirmAlarm), 16'h0001);
      check("positionWord", 16'(positionWord), 16'h0003);
      codeReq <= 3'h0;
      step(10);
   endtask

   // Follow-code start-up takes the code word
   task automatic test_follow_startup();
      startupPolicy <= pss_pkg::PSS_PWR_FOLLOW;
      codeReq       <= 3'h3;
      sys_rst       <= 1'b1;
      step(2);
      sys_rst <= 1'b0;
      step(20);
      check("startup_alarm", 16'(startup_alarm), 16'h0001);
      check("positionWord", 16'(positionWord), 16'h0000);
      step(180);
      check("positionWord", 16'(positionWord), 16'h0003);
      check("startup_alarm", 16'(startup_alarm), 16'h0000);
   endtask

   // Second reset in mid-run
   task automatic test_mid_reset();
      sys_rst <= 1'b1;
      step(2);
      sys_rst <= 1'b0;
      step(2);
      check_idle();
   endtask

   initial begin
      sys_rst = 1'b1;
      pressReq = 1'b0;
      codeReq = 3'h0;
      advanceConfirm = 1'b0;
      code_confirm = 1'b0;
      nvStoredPos = 3'h2;
      startupPolicy = pss_pkg::PSS_PWR_RECALL;
      cfg = '{advanceMode: 1'b0, codeMode: 1'b0, upperLimit: 3'h4,
              timeoutMs: 16'h0005, logEnable: 1'b1};
      error_cnt = 0;
      n_checks = 0;
      nvCnt = 0;
      logCnt = 0;
      lastLog = '0;
      step(5);
      sys_rst <= 1'b0;
      step(2);
      check_idle();
      test_advance_window();
      test_code_window();
      test_confirm_window();
      test_recall_apply();
      test_step_timeout(3'h3);
      test_step_timeout(3'h4);
      test_step_timeout(3'h1);
      test_step_confirm();
      test_code_path();
      test_mid_reset();
      test_follow_startup();
      report_and_stop();
   end

   initial begin
      step(32'h0000_2710);
      error_cnt++;
      report_and_stop();
   end
endmodule // pss_selector_test
`default_nettype wire
